// ---- hdl/cfsc_pkg.sv ----
// Purpose: Shared constants and types of the CRC FIFO and shifter control.
// Assumes: APB register bus with 32-bit data and 8-bit byte addresses.
// Notes: Every register takes one aligned word at the offsets below.
package cfsc_pkg;

  localparam int CFSC_ADDR_W = 8;
  localparam int CFSC_DATA_W = 32;

  // Register offsets.
  localparam logic [7:0] CFSC_OFF_CTRL = 8'h00;
  localparam logic [7:0] CFSC_OFF_POLYNOMIAL_LENGTH = 8'h04;
  localparam logic [7:0] CFSC_OFF_POLY = 8'h08;
  localparam logic [7:0] CFSC_OFF_DATA = 8'h0C;
  localparam logic [7:0] CFSC_OFF_RESULT = 8'h10;
  localparam logic [7:0] CFSC_OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] CFSC_OFF_IRQ_MASK = 8'h18;

  // Control register field positions.
  localparam int CFSC_B_ENABLE = 15;
  localparam int CFSC_B_IDLE_STOP = 13;
  localparam int CFSC_B_COUNT_HI = 12;
  localparam int CFSC_B_COUNT_LO = 8;
  localparam int CFSC_B_FULL = 7;
  localparam int CFSC_B_EMPTY = 6;
  localparam int CFSC_B_ISEL = 5;
  localparam int CFSC_B_START = 4;
  localparam int CFSC_B_LSB_FIRST = 3;

  // Interrupt status and mask bit positions.
  localparam int CFSC_B_IRQ_CRC = 0;
  localparam int CFSC_B_IRQ_OVF = 1;
  localparam int CFSC_IRQ_W = 2;

  // FIFO depth selection by polynomial length.
  localparam int CFSC_FIFO_SLOTS = 16;
  localparam logic [4:0] CFSC_POLYNOMIAL_LENGTH_SHORT_MAX = 5'h07;
  localparam logic [4:0] CFSC_DEPTH_LONG = 5'h08;
  localparam logic [4:0] CFSC_DEPTH_SHORT = 5'h10;

  // Reset values.
  localparam logic [4:0] CFSC_POLYNOMIAL_LENGTH_RST = 5'h00;
  localparam logic [31:0] CFSC_POLY_RST = 32'h0000_0000;
  localparam logic [31:0] CFSC_CRC_RST = 32'h0000_0000;

  typedef enum logic [0:0] {
    CFSC_ST_WAIT = 1'b0,
    CFSC_ST_SHIFT = 1'b1
  } cfsc_state_e;

endpackage

// ---- hdl/cfsc_crc_step.sv ----
// Purpose: One serial bit step of a CRC with programmable length.
// Assumes: The polynomial is given without its top term.
// Notes: Bits above the polynomial length are forced to zero.
`timescale 1ns/100ps
module cfsc_crc_step (
  // Current remainder and configuration
  input wire logic [31:0] crc_in,
  input wire logic [31:0] poly,
  input wire logic [4:0] polynomial_length,
  // Incoming data bit
  input wire logic din,
  // Next remainder
  output logic [31:0] crc_out
);
  logic [31:0] mask;
  logic fb;

  always_comb begin
    mask = 32'hFFFF_FFFF >> (5'h1F - polynomial_length);
    fb = crc_in[polynomial_length] ^ din;
    crc_out = ({crc_in[30:0], 1'b0} ^ (fb ? poly : 32'h0000_0000)) & mask;
  end
endmodule

// ---- hdl/cfsc_crc_control.sv ----
// Purpose: CRC engine control: input FIFO, serial shifter and status.
// Assumes: APB slave, zero wait states, inputs synchronous to pclk.
// Notes: Read data is captured in the setup cycle of each transfer.
`timescale 1ns/100ps
module cfsc_crc_control #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cfsc_pkg::CFSC_ADDR_W-1:0] paddr,
  input wire logic [cfsc_pkg::CFSC_DATA_W-1:0] pwdata,
  output logic [cfsc_pkg::CFSC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // System
  input wire logic device_idle,
  output logic irq
);
  import cfsc_pkg::*;

  localparam int BW = (DATA_W > 1) ? $clog2(DATA_W) : 1;
  localparam int PW = $clog2(CFSC_FIFO_SLOTS);

  if (DATA_W < 2 || DATA_W > 32) begin : g_chk
    $error("DATA_W must lie between 2 and 32");
  end

  // Control and configuration state.
  logic enable_q, enable_d;
  logic idle_stop_q, idle_stop_d;
  logic isel_q, isel_d;
  logic start_q, start_d;
  logic lsb_q, lsb_d;
  logic [4:0] polynomial_length_q, polynomial_length_d;
  logic [31:0] poly_q, poly_d;
  logic [CFSC_IRQ_W-1:0] stat_q, stat_d;
  logic [CFSC_IRQ_W-1:0] mask_q, mask_d;
  logic [31:0] prdata_q, prdata_d;

  // Datapath state.
  logic [DATA_W-1:0] mem_q [CFSC_FIFO_SLOTS];
  logic [PW-1:0] wr_ptr_q, wr_ptr_d;
  logic [PW-1:0] rd_ptr_q, rd_ptr_d;
  logic [4:0] count_q, count_d;
  cfsc_state_e st_q, st_d;
  logic [DATA_W-1:0] shreg_q, shreg_d;
  logic [BW-1:0] bitcnt_q, bitcnt_d;
  logic order_q, order_d;
  logic [31:0] crc_q, crc_d;

  // Decode.
  logic setup, access, wr_acc, rd_setup;
  logic hit_ctrl, hit_polynomial_length, hit_poly, hit_data, hit_res, hit_stat, hit_mask;
  logic mapped;
  logic [4:0] depth_sel;
  logic full, empty, run_ok, push, pop, last_bit, din;
  logic [31:0] crc_next;
  logic [CFSC_IRQ_W-1:0] events;
  logic [15:0] ctrl_view;

  always_comb begin
    setup = psel && !penable;
    access = psel && penable;
    wr_acc = access && pwrite;
    rd_setup = setup && !pwrite;
    hit_ctrl = 1'b0;
    hit_polynomial_length = 1'b0;
    hit_poly = 1'b0;
    hit_data = 1'b0;
    hit_res = 1'b0;
    hit_stat = 1'b0;
    hit_mask = 1'b0;
    if (paddr == CFSC_OFF_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (paddr == CFSC_OFF_POLYNOMIAL_LENGTH) begin
      hit_polynomial_length = 1'b1;
    end else if (paddr == CFSC_OFF_POLY) begin
      hit_poly = 1'b1;
    end else if (paddr == CFSC_OFF_DATA) begin
      hit_data = 1'b1;
    end else if (paddr == CFSC_OFF_RESULT) begin
      hit_res = 1'b1;
    end else if (paddr == CFSC_OFF_IRQ_STAT) begin
      hit_stat = 1'b1;
    end else if (paddr == CFSC_OFF_IRQ_MASK) begin
      hit_mask = 1'b1;
    end
    mapped = hit_ctrl || hit_polynomial_length || hit_poly || hit_data || hit_res ||
             hit_stat || hit_mask;
  end

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_q;
  assign irq = |(stat_q & mask_q);

  // Depth follows the polynomial length; flags come from the count.
  always_comb begin
    depth_sel = (polynomial_length_q > CFSC_POLYNOMIAL_LENGTH_SHORT_MAX) ? CFSC_DEPTH_LONG
                                               : CFSC_DEPTH_SHORT;
    full = (count_q >= depth_sel);
    empty = (count_q == 5'h00);
    run_ok = enable_q && start_q && !(idle_stop_q && device_idle);
    push = wr_acc && hit_data && enable_q && !full;
    pop = (st_q == CFSC_ST_WAIT) && run_ok && !empty;
    last_bit = (st_q == CFSC_ST_SHIFT) && run_ok &&
               (bitcnt_q == BW'(DATA_W - 1));
    din = order_q ? shreg_q[0] : shreg_q[DATA_W-1];
  end

  cfsc_crc_step u_step (
    .crc_in(crc_q),
    .poly(poly_q),
    .polynomial_length(polynomial_length_q),
    .din(din),
    .crc_out(crc_next)
  );

  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[CFSC_B_ENABLE] = enable_q;
    ctrl_view[CFSC_B_IDLE_STOP] = idle_stop_q;
    ctrl_view[CFSC_B_COUNT_HI:CFSC_B_COUNT_LO] = count_q;
    ctrl_view[CFSC_B_FULL] = full;
    ctrl_view[CFSC_B_EMPTY] = empty;
    ctrl_view[CFSC_B_ISEL] = isel_q;
    ctrl_view[CFSC_B_START] = start_q;
    ctrl_view[CFSC_B_LSB_FIRST] = lsb_q;
  end

  // Register file next state.
  always_comb begin
    enable_d = enable_q;
    idle_stop_d = idle_stop_q;
    isel_d = isel_q;
    start_d = start_q;
    lsb_d = lsb_q;
    polynomial_length_d = polynomial_length_q;
    poly_d = poly_q;
    mask_d = mask_q;
    prdata_d = prdata_q;
    if (wr_acc && hit_ctrl) begin
      enable_d = pwdata[CFSC_B_ENABLE];
      idle_stop_d = pwdata[CFSC_B_IDLE_STOP];
      isel_d = pwdata[CFSC_B_ISEL];
      start_d = pwdata[CFSC_B_START];
      lsb_d = pwdata[CFSC_B_LSB_FIRST];
    end
    if (wr_acc && hit_polynomial_length) begin
      polynomial_length_d = pwdata[4:0];
    end
    if (wr_acc && hit_poly) begin
      poly_d = pwdata;
    end
    if (wr_acc && hit_mask) begin
      mask_d = pwdata[CFSC_IRQ_W-1:0];
    end
    if (rd_setup) begin
      prdata_d = 32'h0000_0000;
      if (hit_ctrl) begin
        prdata_d = {16'h0000, ctrl_view};
      end else if (hit_polynomial_length) begin
        prdata_d = {27'h000_0000, polynomial_length_q};
      end else if (hit_poly) begin
        prdata_d = poly_q;
      end else if (hit_res) begin
        prdata_d = crc_q;
      end else if (hit_stat) begin
        prdata_d = {{(32-CFSC_IRQ_W){1'b0}}, stat_q};
      end else if (hit_mask) begin
        prdata_d = {{(32-CFSC_IRQ_W){1'b0}}, mask_q};
      end
    end
  end

  // Sticky events; only bits seen by the read are cleared, so a new
  // event in the same cycle survives.
  always_comb begin
    events = '0;
    if (isel_q) begin
      events[CFSC_B_IRQ_CRC] = pop && (count_q == 5'h01) && !push;
    end else begin
      events[CFSC_B_IRQ_CRC] = last_bit && empty && !push;
    end
    events[CFSC_B_IRQ_OVF] = wr_acc && hit_data && enable_q && full;
    stat_d = stat_q;
    if (access && !pwrite && hit_stat) begin
      stat_d = stat_q & ~prdata_q[CFSC_IRQ_W-1:0];
    end
    stat_d = stat_d | events;
  end

  // FIFO, shifter and result next state.
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d = count_q;
    st_d = st_q;
    shreg_d = shreg_q;
    bitcnt_d = bitcnt_q;
    order_d = order_q;
    crc_d = crc_q;
    if (push) begin
      wr_ptr_d = wr_ptr_q + 1'b1;
    end
    if (pop) begin
      rd_ptr_d = rd_ptr_q + 1'b1;
      shreg_d = mem_q[rd_ptr_q];
      order_d = lsb_q;
      bitcnt_d = '0;
      st_d = CFSC_ST_SHIFT;
    end
    if (push && !pop) begin
      count_d = count_q + 5'h01;
    end else if (pop && !push) begin
      count_d = count_q - 5'h01;
    end
    if (st_q == CFSC_ST_SHIFT && run_ok) begin
      crc_d = crc_next;
      shreg_d = order_q ? (shreg_q >> 1) : (shreg_q << 1);
      bitcnt_d = bitcnt_q + 1'b1;
      if (last_bit) begin
        st_d = CFSC_ST_WAIT;
      end
    end
    if (!enable_q) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      count_d = 5'h00;
      st_d = CFSC_ST_WAIT;
      shreg_d = '0;
      bitcnt_d = '0;
      crc_d = CFSC_CRC_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
      idle_stop_q <= 1'b0;
      isel_q <= 1'b0;
      start_q <= 1'b0;
      lsb_q <= 1'b0;
      polynomial_length_q <= CFSC_POLYNOMIAL_LENGTH_RST;
      poly_q <= CFSC_POLY_RST;
      stat_q <= '0;
      mask_q <= '0;
      prdata_q <= 32'h0000_0000;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= 5'h00;
      st_q <= CFSC_ST_WAIT;
      shreg_q <= '0;
      bitcnt_q <= '0;
      order_q <= 1'b0;
      crc_q <= CFSC_CRC_RST;
    end else begin
      enable_q <= enable_d;
      idle_stop_q <= idle_stop_d;
      isel_q <= isel_d;
      start_q <= start_d;
      lsb_q <= lsb_d;
      polynomial_length_q <= polynomial_length_d;
      poly_q <= poly_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      prdata_q <= prdata_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
      st_q <= st_d;
      shreg_q <= shreg_d;
      bitcnt_q <= bitcnt_d;
      order_q <= order_d;
      crc_q <= crc_d;
    end
  end

  // The storage array has no reset; the count guards every read of it.
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= pwdata[DATA_W-1:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_idle_halt;
    (st_q == CFSC_ST_SHIFT) && enable_q && idle_stop_q && device_idle
      |=> $stable(crc_q) && $stable(bitcnt_q);
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("engine ran in idle with stop set");

  property p_idle_run;
    (st_q == CFSC_ST_SHIFT) && enable_q && start_q && device_idle &&
      !idle_stop_q |=> bitcnt_q != $past(bitcnt_q) || st_q == CFSC_ST_WAIT;
  endproperty
  a_idle_run: assert property (p_idle_run)
    else $error("engine stopped in idle with stop clear");

  property p_count_read;
    rd_setup && hit_ctrl |=> prdata_q[12:8] == $past(count_q);
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("count field wrong");

  property p_depth_long;
    push && (polynomial_length_q > 5'h07) |=> count_q <= 5'h08;
  endproperty
  a_depth_long: assert property (p_depth_long)
    else $error("long polynomial FIFO exceeded eight");

  property p_full;
    rd_setup && hit_ctrl |=> prdata_q[7] == $past(count_q >= depth_sel);
  endproperty
  a_full: assert property (p_full)
    else $error("full flag wrong");

  property p_empty;
    rd_setup && hit_ctrl |=> prdata_q[6] == ($past(count_q) == 5'h00);
  endproperty
  a_empty: assert property (p_empty)
    else $error("empty flag wrong");

  property p_irq_empty;
    isel_q && pop && (count_q == 5'h01) && !push |=> stat_q[0];
  endproperty
  a_irq_empty: assert property (p_irq_empty)
    else $error("no interrupt on FIFO empty");

  property p_irq_done;
    $past(!isel_q) && $rose(stat_q[0]) |-> $past(last_bit && empty);
  endproperty
  a_irq_done: assert property (p_irq_done)
    else $error("shift-done interrupt at wrong time");

  property p_start_off;
    (st_q == CFSC_ST_WAIT) && !start_q |=> st_q == CFSC_ST_WAIT;
  endproperty
  a_start_off: assert property (p_start_off)
    else $error("shifter started without start bit");

  property p_order;
    pop |=> din == ($past(lsb_q) ? $past(mem_q[rd_ptr_q][0])
                                 : $past(mem_q[rd_ptr_q][DATA_W-1]));
  endproperty
  a_order: assert property (p_order)
    else $error("first bit of word in wrong order");

  property p_unimpl;
    rd_setup && hit_ctrl |=> prdata_q[31:16] == 16'h0000 &&
      !prdata_q[14] && prdata_q[2:0] == 3'h0;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bits not zero");

  property p_disable;
    !enable_q |=> count_q == 5'h00 && crc_q == CFSC_CRC_RST &&
      st_q == CFSC_ST_WAIT;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable did not clear state");

  c_fill: cover property (full && push == 1'b0 && wr_acc && hit_data);
  c_word_done: cover property (last_bit ##1 stat_q[0]);
  c_idle_hold: cover property ((st_q == CFSC_ST_SHIFT) && !run_ok [*3]);
endmodule

// ---- sim/test_crc_fifo_shifter_control.sv ----
// Purpose: Self-checking bench for the CRC FIFO and shifter control block.
// Assumes: Zero-wait APB slave; CRC seed zero, MSB of remainder feeds back.
// Notes: The bench drives every port itself; no random stimulus is used.
`timescale 1ns/100ps
module test_crc_fifo_shifter_control;
  import cfsc_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic device_idle = 1'b0;
  logic irq;
  logic [31:0] rd;
  logic last_err;
  int num_errors = 0;
  int n_checks = 0;
  int cyc;

  always #25 pclk = ~pclk;

  cfsc_crc_control #(.DATA_W(16)) dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .device_idle(device_idle),
    .irq(irq)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 100) begin
      num_errors++;
      test_done();
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rd);
    chk(rd, exp);
  endtask

  // Waits for the interrupt line, counting cycles, with a bound.
  task automatic wait_irq(input int lim);
    cyc = 0;
    while (irq !== 1'b1 && cyc < lim) begin
      @(posedge pclk);
      cyc++;
    end
  endtask

  function automatic logic [31:0] crc_ref(input logic [15:0] w,
      input logic [4:0] pl, input logic [31:0] poly, input logic lsb);
    logic [31:0] c;
    logic [31:0] m;
    logic fb;
    c = 32'h0000_0000;
    m = (pl == 5'd31) ? 32'hFFFF_FFFF : ((32'h0000_0001 << (pl + 1)) - 1);
    for (int i = 0; i < 16; i++) begin
      fb = c[pl] ^ (lsb ? w[i] : w[15 - i]);
      c = (c << 1) & m;
      if (fb) c = c ^ (poly & m);
    end
    return c;
  endfunction

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state, reserved bits and an unmapped address.
    rdchk(CFSC_OFF_CTRL, 32'h0000_0040);
    rdchk(CFSC_OFF_IRQ_STAT, 32'h0000_0000);
    chk({31'h0, last_err}, 32'h0000_0000);
    chk({31'h0, pready}, 32'h0000_0001);
    wr(CFSC_OFF_CTRL, 32'h0000_6007);
    rdchk(CFSC_OFF_CTRL, 32'h0000_2040);
    rdchk(8'h1C, 32'h0000_0000);
    chk({31'h0, last_err}, 32'h0000_0001);
    wr(CFSC_OFF_CTRL, 32'h0000_0000);
    $display("test reset done");
    // Fill to depth 8, overflow, then widen the depth to 16.
    wr(CFSC_OFF_POLYNOMIAL_LENGTH, 32'h0000_0008);
    wr(CFSC_OFF_CTRL, 32'h0000_8000);
    for (int i = 0; i < 8; i++) wr(CFSC_OFF_DATA, 32'h0000_1000 + i);
    rdchk(CFSC_OFF_CTRL, 32'h0000_8880);
    wr(CFSC_OFF_DATA, 32'h0000_BEEF);
    rdchk(CFSC_OFF_CTRL, 32'h0000_8880);
    rdchk(CFSC_OFF_IRQ_STAT, 32'h0000_0002);
    wr(CFSC_OFF_POLYNOMIAL_LENGTH, 32'h0000_0007);
    rdchk(CFSC_OFF_CTRL, 32'h0000_8800);
    for (int i = 0; i < 8; i++) wr(CFSC_OFF_DATA, 32'h0000_2000 + i);
    rdchk(CFSC_OFF_CTRL, 32'h0000_9080);
    wr(CFSC_OFF_CTRL, 32'h0000_0000);
    rdchk(CFSC_OFF_CTRL, 32'h0000_0040);
    rdchk(CFSC_OFF_POLYNOMIAL_LENGTH, 32'h0000_0007);
    $display("test fifo done");
    // Idle stop holds the word; release lets it through, MSB first.
    wr(CFSC_OFF_POLYNOMIAL_LENGTH, 32'h0000_000F);
    wr(CFSC_OFF_POLY, 32'h0000_1021);
    wr(CFSC_OFF_IRQ_MASK, 32'h0000_0001);
    device_idle <= 1'b1;
    wr(CFSC_OFF_CTRL, 32'h0000_A010);
    wr(CFSC_OFF_DATA, 32'h0000_1234);
    repeat (30) @(posedge pclk);
    rdchk(CFSC_OFF_CTRL, 32'h0000_A110);
    device_idle <= 1'b0;
    wait_irq(200);
    chk({31'h0, cyc >= 16 && cyc < 200}, 32'h0000_0001);
    rdchk(CFSC_OFF_RESULT, crc_ref(16'h1234, 5'd15, 32'h1021, 1'b0));
    rdchk(CFSC_OFF_IRQ_STAT, 32'h0000_0001);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test idle done");
    // Start off holds the word; start with LSB first consumes it.
    wr(CFSC_OFF_CTRL, 32'h0000_0000);
    wr(CFSC_OFF_CTRL, 32'h0000_8000);
    wr(CFSC_OFF_DATA, 32'h0000_00A5);
    repeat (30) @(posedge pclk);
    rdchk(CFSC_OFF_CTRL, 32'h0000_8100);
    wr(CFSC_OFF_CTRL, 32'h0000_8018);
    wait_irq(200);
    rdchk(CFSC_OFF_RESULT, crc_ref(16'h00A5, 5'd15, 32'h1021, 1'b1));
    rdchk(CFSC_OFF_IRQ_STAT, 32'h0000_0001);
    $display("test start done");
    // Interrupt on empty comes before shifting ends; idle without stop runs.
    wr(CFSC_OFF_CTRL, 32'h0000_0000);
    device_idle <= 1'b1;
    wr(CFSC_OFF_CTRL, 32'h0000_8030);
    wr(CFSC_OFF_DATA, 32'h0000_5A5A);
    wait_irq(200);
    chk({31'h0, cyc < 16}, 32'h0000_0001);
    repeat (30) @(posedge pclk);
    rdchk(CFSC_OFF_RESULT, crc_ref(16'h5A5A, 5'd15, 32'h1021, 1'b0));
    rdchk(CFSC_OFF_IRQ_STAT, 32'h0000_0001);
    device_idle <= 1'b0;
    // A masked event stays in status but keeps the line low. Idle with
    // stop set freezes the word in mid-shift without losing any bit.
    wr(CFSC_OFF_IRQ_MASK, 32'h0000_0000);
    wr(CFSC_OFF_CTRL, 32'h0000_0000);
    wr(CFSC_OFF_CTRL, 32'h0000_A010);
    wr(CFSC_OFF_DATA, 32'h0000_0001);
    repeat (5) @(posedge pclk);
    device_idle <= 1'b1;
    repeat (10) @(posedge pclk);
    rdchk(CFSC_OFF_IRQ_STAT, 32'h0000_0000);
    device_idle <= 1'b0;
    repeat (40) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0000);
    rdchk(CFSC_OFF_IRQ_STAT, 32'h0000_0001);
    rdchk(CFSC_OFF_RESULT, crc_ref(16'h0001, 5'd15, 32'h1021, 1'b0));
    $display("test interrupt done");
    test_done();
  end
endmodule
